//--- core/trace_capture.v
/*
 * trace capture unit: samples one frame per target bus cycle into a circular
 * buffer, filters by qualifiers, counts a post-trigger delay, wishbone registers.
 * assumes target pins are asynchronous to clk_i and held stable around the frame strobe.
 */
// Function
// [R1] frame holds fetch, write or read code
// [R2] read/write tagged only for external data space
// [R3] frame records interrupt nesting level
// [R4] frame records both port states, address, data
// [R5] frame records four pod probe inputs
// [R6] starting emulation starts capture
// [R7] halt command stops capture, status shows stopped
// [R8] resume command restarts capture while emulating
// [R9] circular buffer keeps last 64k frames
// [R10] emulation indicator lit while emulating
// [R11] conditional record stores only matching frames
// [R12] term ANDs address range and wildcard fields
// [R13] eight qualifiers, two ORed terms each
// [R14] cycle type 01 selects opcode fetch
// [R15] trigger counts delay down, stops at zero
// [R16] trigger frame position kept for relative indexing
// [R17] break on done halts emulation, needs trigger
// [R18] without trigger, overwrite oldest frames forever
// [R19] one frame per target bus cycle
`include "trace_capture_map.vh"
`timescale 1ns/1ps
`default_nettype none

module trace_capture (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        bus_cycle_i,
    input  wire        fetch_i,
    input  wire        mem_write_i,
    input  wire        mem_read_i,
    input  wire        external_data_space_i,
    input  wire [15:0] bus_addr_i,
    input  wire [7:0]  bus_byte_field_i,
    input  wire [2:0]  int_level_i,
    input  wire [7:0]  port_one_state_i,
    input  wire [7:0]  port_three_state_i,
    input  wire        pod_sync_input_one_i,
    input  wire        pod_sync_input_zero_i,
    input  wire        pod_ext_input_one_i,
    input  wire        pod_ext_input_zero_i,
    output reg         emu_led_o,
    output reg         emu_break_o,
    output reg         irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam PIN_W = 52;
    wire [PIN_W-1:0] pin_raw;
    reg  [PIN_W-1:0] pin_s1_reg;
    reg  [PIN_W-1:0] pin_s2_reg;
    reg              strobe_d_reg;

    // one vector, so all fields cross in the same flops; strobe on top
    assign pin_raw = {bus_cycle_i,
                      fetch_i,
                      mem_write_i,
                      mem_read_i,
                      external_data_space_i,
                      pod_sync_input_one_i,
                      pod_sync_input_zero_i,
                      pod_ext_input_one_i,
                      pod_ext_input_zero_i,
                      port_three_state_i,
                      port_one_state_i,
                      int_level_i,
                      bus_byte_field_i,
                      bus_addr_i};

    always @(posedge clk_i) begin
        pin_s1_reg   <= pin_raw;
        pin_s2_reg   <= pin_s1_reg;
        strobe_d_reg <= pin_s2_reg[`PIN_STROBE];
    end

    wire [15:0] s_addr = pin_s2_reg[`PIN_ADDR_LO+15:`PIN_ADDR_LO];
    wire [7:0]  s_data = pin_s2_reg[`PIN_DATA_LO+7:`PIN_DATA_LO];
    wire [2:0]  s_int  = pin_s2_reg[`PIN_INT_LO+2:`PIN_INT_LO];
    wire [7:0]  s_p1   = pin_s2_reg[`PIN_P1_LO+7:`PIN_P1_LO];
    wire [7:0]  s_p3   = pin_s2_reg[`PIN_P3_LO+7:`PIN_P3_LO];
    wire [3:0]  s_pod  = pin_s2_reg[`PIN_POD_LO+3:`PIN_POD_LO];
    wire        s_xds  = pin_s2_reg[`PIN_XDS];
    wire        s_rd   = pin_s2_reg[`PIN_RD];
    wire        s_wr   = pin_s2_reg[`PIN_WR];
    wire        s_fet  = pin_s2_reg[`PIN_FET];

    // [R19] one strobe edge
    // edge, not level: a long bus cycle still gives one frame
    wire frame_edge = pin_s2_reg[`PIN_STROBE] & ~strobe_d_reg;

    // [R2] external_data_space-only tagging
    reg [1:0] s_type;
    always @* begin
        // [R1] cycle type code
        if (s_fet)
            s_type = `CT_FETCH;
        else if (s_wr & s_xds)
            s_type = `CT_WRITE;
        else if (s_rd & s_xds)
            s_type = `CT_READ;
        else
            s_type = `CT_NONE;
    end

    // [R3] level, [R4] ports, [R5] pod inputs
    wire [`FRAME_W-1:0] frame = {s_pod, s_p3, s_p1, s_int, s_data, s_addr, s_type};

    ////////////////////////////////////////////////////////////////////////////
    // qualifier terms
    reg [31:0] term_w0_reg [0:`NUM_TERMS-1];
    reg [31:0] term_w1_reg [0:`NUM_TERMS-1];
    reg [31:0] term_w2_reg [0:`NUM_TERMS-1];
    reg [15:0] term_en_reg;
    wire [`NUM_TERMS-1:0] term_hit;
    wire [7:0]            qual_hit;

    genvar g;
    generate
        for (g = 0; g < `NUM_TERMS; g = g + 1) begin : g_term
            wire [31:0] w0 = term_w0_reg[g];
            wire [31:0] w1 = term_w1_reg[g];
            wire [31:0] w2 = term_w2_reg[g];
            // [R12] range and masked fields ANDed
            wire a_ok = (s_addr >= w0[15:0]) && (s_addr <= w0[31:16]);
            wire d_ok = ((s_data ^ w1[7:0]) & w1[15:8]) == 8'h00;
            // [R14] type compare, 01 = fetch
            wire t_ok = ((s_type ^ w1[17:16]) & w1[19:18]) == 2'h0;
            wire i_ok = ((s_int ^ w1[22:20]) & w1[26:24]) == 3'h0;
            wire p_ok = (((s_p1 ^ w2[7:0]) & w2[15:8]) == 8'h00) &&
                        (((s_p3 ^ w2[23:16]) & w2[31:24]) == 8'h00);
            assign term_hit[g] = term_en_reg[g] & a_ok & d_ok & t_ok & i_ok & p_ok;
        end
        for (g = 0; g < 8; g = g + 1) begin : g_qual
            // [R13] two terms ORed
            assign qual_hit[g] = term_hit[2*g] | term_hit[2*g+1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // control state
    reg [`CTRL_W-1:0]  ctrl_reg;
    reg                capturing_reg;
    reg                triggered_reg;
    reg                done_reg;
    reg                wrapped_reg;
    reg [`DLY_W-1:0]   dly_preset_reg;
    reg [`DLY_W-1:0]   dly_count_reg;
    reg [`PTR_W-1:0]   wptr_reg;
    reg [`PTR_W-1:0]   trig_ptr_reg;
    reg [`PTR_W-1:0]   rd_addr_reg;
    reg [`EV_W-1:0]    irq_stat_reg;
    reg [`EV_W-1:0]    irq_mask_reg;
    reg [`FRAME_W-1:0] rd_frame_reg;

    wire [2:0] rec_q  = ctrl_reg[`CTRL_REC_Q_LO+2:`CTRL_REC_Q_LO];
    wire [2:0] trig_q = ctrl_reg[`CTRL_TRIG_Q_LO+2:`CTRL_TRIG_Q_LO];
    wire trig_en = ctrl_reg[`CTRL_TRIG_EN];

    wire frame_ev = frame_edge & capturing_reg;
    // [R11] conditional record filter
    wire store = frame_ev & (~ctrl_reg[`CTRL_REC_COND] | qual_hit[rec_q]);
    // [R15] trigger on a stored matching frame
    wire trig_fire = store & trig_en & ~triggered_reg & qual_hit[trig_q];
    wire count_end = store & triggered_reg & ~done_reg & (dly_count_reg == `DLY_W'h1);
    wire done_ev = count_end | (trig_fire & (dly_preset_reg == {`DLY_W{1'b0}}));
    // [R9] pointer wraps
    wire wrap_ev = store & (wptr_reg == {`PTR_W{1'b1}});

    ////////////////////////////////////////////////////////////////////////////
    // frame buffer
    reg [`FRAME_W-1:0] buffer_mem [0:(1<<`PTR_W)-1];

    always @(posedge clk_i) begin
        // [R9] circular store, [R18] oldest overwritten
        if (store)
            buffer_mem[wptr_reg] <= frame;
        rd_frame_reg <= buffer_mem[rd_addr_reg];
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode
    wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr  = wb_req & wb_we_i;
    wire        is_term = (wb_adr_i[11:8] == `TERM_BASE_HI);
    wire [3:0]  t_idx  = wb_adr_i[7:4];
    wire [1:0]  t_word = wb_adr_i[3:2];
    wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    wire [31:0] ctrl_new = merge({{(32-`CTRL_W){1'b0}}, ctrl_reg}, wb_dat_i, sel_mask);
    // merged words, cut to register width where they are used
    wire [31:0] preset_wr  = merge({16'h0, dly_preset_reg}, wb_dat_i, sel_mask);
    wire [31:0] rd_addr_wr = merge({16'h0, rd_addr_reg}, wb_dat_i, sel_mask);
    wire [31:0] term_en_wr = merge({16'h0, term_en_reg}, wb_dat_i, sel_mask);
    // write-one-to-clear pattern for the event flags
    wire [`EV_W-1:0] irq_clr = (wb_wr & (wb_adr_i == `OFF_IRQ_STAT) & wb_sel_i[0]) ? wb_dat_i[`EV_W-1:0]
                                                                                    : {`EV_W{1'b0}};
    wire wr_ctrl = wb_wr & (wb_adr_i == `OFF_CTRL);
    wire wr_cmd  = wb_wr & (wb_adr_i == `OFF_CMD);
    wire emu_start = wr_ctrl & ctrl_new[`CTRL_EMU_RUN] & ~ctrl_reg[`CTRL_EMU_RUN];
    wire emu_stop  = wr_ctrl & ~ctrl_new[`CTRL_EMU_RUN];
    wire cmd_halt   = wr_cmd & wb_sel_i[0] & wb_dat_i[`CMD_HALT];
    wire cmd_resume = wr_cmd & wb_sel_i[0] & wb_dat_i[`CMD_RESUME];
    // [R17] break needs trigger enabled
    wire brk = done_ev & ctrl_reg[`CTRL_BRK_DONE] & trig_en;

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (is_term) begin
            case (t_word)
                2'h0:    rd_mux = term_w0_reg[t_idx];
                2'h1:    rd_mux = term_w1_reg[t_idx];
                2'h2:    rd_mux = term_w2_reg[t_idx];
                default: rd_mux = 32'h0000_0000;
            endcase
        end else begin
            case (wb_adr_i)
                `OFF_CTRL:       rd_mux = {{(32-`CTRL_W){1'b0}}, ctrl_reg};
                // [R7] stopped flag visible
                `OFF_STATUS:     rd_mux = {27'h0, wrapped_reg, ~capturing_reg & ctrl_reg[`CTRL_EMU_RUN],
                                           done_reg, triggered_reg, capturing_reg};
                `OFF_DLY_PRESET: rd_mux = {16'h0, dly_preset_reg};
                `OFF_DLY_COUNT:  rd_mux = {16'h0, dly_count_reg};
                `OFF_WPTR:       rd_mux = {16'h0, wptr_reg};
                // [R16] trigger frame slot
                `OFF_TRIG_PTR:   rd_mux = {16'h0, trig_ptr_reg};
                `OFF_RD_ADDR:    rd_mux = {16'h0, rd_addr_reg};
                `OFF_RD_LO:      rd_mux = rd_frame_reg[31:0];
                `OFF_RD_HI:      rd_mux = {15'h0, rd_frame_reg[`FRAME_W-1:32]};
                `OFF_IRQ_STAT:   rd_mux = {29'h0, irq_stat_reg};
                `OFF_IRQ_MASK:   rd_mux = {29'h0, irq_mask_reg};
                `OFF_TERM_EN:    rd_mux = {16'h0, term_en_reg};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and capture sequencing
    integer k;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h0000_0000;
            ctrl_reg       <= {`CTRL_W{1'b0}};
            capturing_reg  <= 1'b0;
            triggered_reg  <= 1'b0;
            done_reg       <= 1'b0;
            wrapped_reg    <= 1'b0;
            dly_preset_reg <= `DLY_DEFAULT;
            dly_count_reg  <= `DLY_DEFAULT;
            wptr_reg       <= {`PTR_W{1'b0}};
            trig_ptr_reg   <= {`PTR_W{1'b0}};
            rd_addr_reg    <= {`PTR_W{1'b0}};
            irq_stat_reg   <= {`EV_W{1'b0}};
            irq_mask_reg   <= {`EV_W{1'b0}};
            term_en_reg    <= 16'h0000;
            emu_led_o      <= 1'b0;
            emu_break_o    <= 1'b0;
            irq_o          <= 1'b0;
            for (k = 0; k < `NUM_TERMS; k = k + 1) begin
                term_w0_reg[k] <= `TERM_ADDR_RST;
                term_w1_reg[k] <= 32'h0000_0000;
                term_w2_reg[k] <= 32'h0000_0000;
            end
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
            if (wb_wr) begin
                if (is_term) begin
                    case (t_word)
                        2'h0:    term_w0_reg[t_idx] <= merge(term_w0_reg[t_idx], wb_dat_i, sel_mask);
                        2'h1:    term_w1_reg[t_idx] <= merge(term_w1_reg[t_idx], wb_dat_i, sel_mask);
                        2'h2:    term_w2_reg[t_idx] <= merge(term_w2_reg[t_idx], wb_dat_i, sel_mask);
                        default: term_w0_reg[t_idx] <= term_w0_reg[t_idx];
                    endcase
                end else begin
                    case (wb_adr_i)
                        `OFF_DLY_PRESET: dly_preset_reg <= preset_wr[`DLY_W-1:0];
                        `OFF_RD_ADDR:    rd_addr_reg <= rd_addr_wr[`PTR_W-1:0];
                        `OFF_IRQ_MASK:   irq_mask_reg <= wb_sel_i[0] ? wb_dat_i[`EV_W-1:0] : irq_mask_reg;
                        `OFF_TERM_EN:    term_en_reg <= term_en_wr[15:0];
                        default:         ;
                    endcase
                end
            end

            // ctrl: software write, break clears the run bit
            if (brk)
                ctrl_reg[`CTRL_EMU_RUN] <= 1'b0;
            else if (wr_ctrl)
                ctrl_reg <= ctrl_new[`CTRL_W-1:0];

            // [R6] start arms capture, [R7] halt, [R8] resume
            if (emu_start) begin
                capturing_reg <= 1'b1;
                triggered_reg <= 1'b0;
                done_reg      <= 1'b0;
                wrapped_reg   <= 1'b0;
                wptr_reg      <= {`PTR_W{1'b0}};
                dly_count_reg <= dly_preset_reg;
            end else if (emu_stop | cmd_halt | done_ev) begin
                capturing_reg <= 1'b0;
            end else if (cmd_resume & ctrl_reg[`CTRL_EMU_RUN] & ~done_reg) begin
                capturing_reg <= 1'b1;
            end

            if (store & ~emu_start) begin
                wptr_reg <= wptr_reg + `PTR_W'h1;
                if (wrap_ev)
                    wrapped_reg <= 1'b1;
            end
            // [R15] load, decrement, stop at zero
            if (trig_fire & ~emu_start) begin
                triggered_reg <= 1'b1;
                trig_ptr_reg  <= wptr_reg;
                dly_count_reg <= dly_preset_reg;
            end else if (store & triggered_reg & ~done_reg & ~emu_start) begin
                dly_count_reg <= dly_count_reg - `DLY_W'h1;
            end
            if (done_ev & ~emu_start)
                done_reg <= 1'b1;

            // events: set wins over write-one-to-clear
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {wrap_ev, done_ev, trig_fire};
            irq_o <= |(irq_stat_reg & irq_mask_reg);
            // [R10] indicator follows emulation, not capture
            emu_led_o   <= brk ? 1'b0 : (wr_ctrl ? ctrl_new[`CTRL_EMU_RUN] : ctrl_reg[`CTRL_EMU_RUN]);
            emu_break_o <= brk;
        end
    end

endmodule // trace_capture

`default_nettype wire

//--- core/trace_capture_map.vh
/*
 * register map, field positions, frame layout and reset values of the trace capture unit.
 * assumes a 32-bit classic wishbone slave with byte addresses.
 */
`ifndef TRACE_CAPTURE_MAP_VH
`define TRACE_CAPTURE_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_CMD         12'h004
`define OFF_STATUS      12'h008
`define OFF_DLY_PRESET  12'h00C
`define OFF_DLY_COUNT   12'h010
`define OFF_WPTR        12'h014
`define OFF_TRIG_PTR    12'h018
`define OFF_RD_ADDR     12'h01C
`define OFF_RD_LO       12'h020
`define OFF_RD_HI       12'h024
`define OFF_IRQ_STAT    12'h028
`define OFF_IRQ_MASK    12'h02C
`define OFF_TERM_EN     12'h030
`define TERM_BASE_HI    4'h1

////////////////////////////////////////////////////////////////////////////////
// control and command bits
`define CTRL_EMU_RUN    0
`define CTRL_REC_COND   1
`define CTRL_REC_Q_LO   2
`define CTRL_TRIG_EN    5
`define CTRL_TRIG_Q_LO  6
`define CTRL_BRK_DONE   9
`define CTRL_W          10
`define CMD_HALT        0
`define CMD_RESUME      1

////////////////////////////////////////////////////////////////////////////////
// cycle type codes and interrupt events
`define CT_NONE         2'h0
`define CT_FETCH        2'h1
`define CT_READ         2'h2
`define CT_WRITE        2'h3
`define EV_TRIG         0
`define EV_DONE         1
`define EV_WRAP         2
`define EV_W            3

////////////////////////////////////////////////////////////////////////////////
// frame layout, buffer size, reset values
`define FRAME_W         49
`define PTR_W           16
`define DLY_W           16
`define DLY_DEFAULT     16'h8000
`define TERM_ADDR_RST   32'hFFFF0000
`define NUM_TERMS       16

////////////////////////////////////////////////////////////////////////////////
// synchronised pin vector layout
`define PIN_ADDR_LO     0
`define PIN_DATA_LO     16
`define PIN_INT_LO      24
`define PIN_P1_LO       27
`define PIN_P3_LO       35
`define PIN_POD_LO      43
`define PIN_XDS         47
`define PIN_RD          48
`define PIN_WR          49
`define PIN_FET         50
`define PIN_STROBE      51

`endif

//--- tb/trace_capture_asserts.sv
/* checker: wishbone answer timing and output behaviour of the trace capture unit.
   assumes it is bound onto trace_capture and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module trace_capture_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        emu_led_o,
    input wire logic        emu_break_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i;
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over one cycle");
    property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("request not answered next cycle");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_brk_pulse; emu_break_o |=> !emu_break_o; endproperty
    a_brk_pulse: assert property (p_brk_pulse) else $error("break longer than one cycle");
    property p_brk_run; emu_break_o |-> $past(emu_led_o) ##0 (##[0:1] !emu_led_o); endproperty
    a_brk_run: assert property (p_brk_run) else $error("break did not end emulation");
    property p_led_on; $rose(emu_led_o) |-> $past(wr) || $past(wr, 2); endproperty
    a_led_on: assert property (p_led_on) else $error("indicator lit without a write");
    property p_led_off;
        $fell(emu_led_o) |-> $past(wr) || $past(wr, 2) || emu_break_o || $past(emu_break_o);
    endproperty
    a_led_off: assert property (p_led_off) else $error("indicator dropped by itself");
    property p_irq_off; $fell(irq_o) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt dropped without a write");
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_break: cover property (emu_break_o);
    c_irq: cover property ($rose(irq_o));
endmodule // trace_capture_asserts
bind trace_capture trace_capture_asserts i_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .emu_led_o(emu_led_o), .emu_break_o(emu_break_o), .irq_o(irq_o));
`default_nettype wire

//--- tb/trace_capture_tb.sv
/* testbench: register tasks over wishbone, frame capture, halt, filter, trigger.
   assumes trace_capture and its map header; target side is trace_target_model. */
`timescale 1ns/1ps
`default_nettype none
`include "trace_capture_map.vh"
module trace_capture_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h0;
    logic [31:0] wb_dat = 32'h0, q;
    logic [48:0] exp_f;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, emu_led_o, emu_break_o, irq_o, bus_cycle;
    wire  [3:0]  kind, pod;
    wire  [15:0] addr;
    wire  [7:0]  data, p1, p3;
    wire  [2:0]  lvl;
    int err_count = 0, check_count = 0, brk_seen = 0;
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (emu_break_o === 1'b1) brk_seen <= brk_seen + 1;
    trace_target_model i_tgt (.clk_i(clk_i), .bus_cycle_o(bus_cycle), .kind_o(kind), .addr_o(addr),
        .data_o(data), .lvl_o(lvl), .p1_o(p1), .p3_o(p3), .pod_o(pod));
    trace_capture i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bus_cycle_i(bus_cycle), .fetch_i(kind[3]), .mem_write_i(kind[2]),
        .mem_read_i(kind[1]), .external_data_space_i(kind[0]), .bus_addr_i(addr),
        .bus_byte_field_i(data), .int_level_i(lvl), .port_one_state_i(p1), .port_three_state_i(p3),
        .pod_sync_input_one_i(pod[3]), .pod_sync_input_zero_i(pod[2]), .pod_ext_input_one_i(pod[1]),
        .pod_ext_input_zero_i(pod[0]), .emu_led_o(emu_led_o), .emu_break_o(emu_break_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task flag(input logic f, input logic e);
        chk({31'h0, f}, {31'h0, e});
    endtask
    // one classic cycle; waits for ack, only the watchdog ends a wait that gets none
    task xfer(input [11:0] a, input w, input [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task rd(input [11:0] a, input [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(q, e);
    endtask
    // level, ports and pod derived from address and data so each frame differs
    task cap(input [3:0] k, input [15:0] a, input [7:0] d);
        logic [1:0] t;
        t = k[3] ? `CT_FETCH : (k[2] & k[0]) ? `CT_WRITE : (k[1] & k[0]) ? `CT_READ : `CT_NONE;
        exp_f = {a[3:0], a[15:8], ~d, a[2:0], d, a, t};
        i_tgt.send(k, a, d, a[2:0], ~d, a[15:8], a[3:0]);
    endtask
    task slot(input [15:0] s);
        xfer(`OFF_RD_ADDR, 1'b1, {16'h0, s});
        rd(`OFF_RD_LO, exp_f[31:0]);
        rd(`OFF_RD_HI, {15'h0, exp_f[48:32]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`OFF_DLY_PRESET, 32'h8000);
        rd(`OFF_STATUS, 32'h0);
        rd(12'h0FC, 32'h0);
        flag(emu_led_o, 1'b0);
        $display("test reset done");
        xfer(`OFF_CTRL, 1'b1, 32'h1);
        rd(`OFF_STATUS, 32'h1);
        flag(emu_led_o, 1'b1);
        cap(4'b1011, 16'h0205, 8'h32);
        slot(0);
        cap(4'b0101, 16'h408A, 8'h00);
        slot(1);
        cap(4'b0010, 16'h1234, 8'h77);
        slot(2);
        cap(4'b0011, 16'hFFFF, 8'hC3);
        slot(3);
        rd(`OFF_WPTR, 32'h4);
        $display("test frames done");
        xfer(`OFF_CMD, 1'b1, 32'h1 << `CMD_HALT);
        rd(`OFF_STATUS, 32'h8);
        flag(emu_led_o, 1'b1);
        cap(4'b0101, 16'h4000, 8'h01);
        rd(`OFF_WPTR, 32'h4);
        xfer(`OFF_CMD, 1'b1, 32'h1 << `CMD_RESUME);
        rd(`OFF_STATUS, 32'h1);
        cap(4'b1000, 16'h0810, 8'h5A);
        slot(4);
        $display("test halt done");
        xfer(12'h100, 1'b1, 32'h50004000);
        xfer(12'h104, 1'b1, 32'h000FFF00);
        xfer(`OFF_TERM_EN, 1'b1, 32'h1);
        xfer(`OFF_CTRL, 1'b1, 32'h3);
        cap(4'b0101, 16'h6000, 8'h00);
        cap(4'b0011, 16'h4800, 8'h00);
        cap(4'b0101, 16'h4FFF, 8'h9E);
        cap(4'b0101, 16'h5000, 8'h00);
        slot(5);
        rd(`OFF_WPTR, 32'h6);
        $display("test filter done");
        xfer(`OFF_CTRL, 1'b1, 32'h0);
        xfer(`OFF_DLY_PRESET, 1'b1, 32'h1);
        xfer(`OFF_IRQ_MASK, 1'b1, 32'h2);
        xfer(`OFF_TERM_EN, 1'b1, 32'h8000);
        xfer(12'h1F0, 1'b1, 32'h02050205);
        xfer(12'h1F4, 1'b1, 32'h000D0000);
        xfer(`OFF_CTRL, 1'b1, 32'h3E1);
        rd(`OFF_WPTR, 32'h0);
        cap(4'b1000, 16'h0100, 8'h00);
        cap(4'b1000, 16'h0205, 8'h32);
        rd(`OFF_STATUS, 32'h3);
        rd(`OFF_DLY_COUNT, 32'h1);
        rd(`OFF_TRIG_PTR, 32'h1);
        flag(irq_o, 1'b0);
        cap(4'b1000, 16'h0206, 8'h00);
        rd(`OFF_STATUS, 32'h6);
        rd(`OFF_DLY_COUNT, 32'h0);
        chk(brk_seen, 32'h1);
        flag(emu_led_o, 1'b0);
        flag(irq_o, 1'b1);
        rd(`OFF_IRQ_STAT, 32'h3);
        xfer(`OFF_IRQ_STAT, 1'b1, 32'h2);
        rd(`OFF_IRQ_STAT, 32'h1);
        flag(irq_o, 1'b0);
        cap(4'b1000, 16'h0300, 8'h00);
        rd(`OFF_WPTR, 32'h3);
        $display("test trigger done");
        close_out;
    end
    initial begin
        repeat (10000) @(posedge clk_i);
        err_count++;
        $display("watchdog expired");
        close_out;
    end
endmodule // trace_capture_tb
`default_nettype wire

//--- tb/trace_target_model.sv
/* emulated target bus: presents one frame per bus cycle strobe.
   assumes the bench calls send() and nothing else drives these lines. */
`timescale 1ns/1ps
`default_nettype none
module trace_target_model (
    input  wire logic        clk_i,
    output var  logic        bus_cycle_o,
    output var  logic [3:0]  kind_o,
    output var  logic [15:0] addr_o,
    output var  logic [7:0]  data_o,
    output var  logic [2:0]  lvl_o,
    output var  logic [7:0]  p1_o,
    output var  logic [7:0]  p3_o,
    output var  logic [3:0]  pod_o
);
    initial begin
        {bus_cycle_o, kind_o, addr_o, data_o, lvl_o, p1_o, p3_o, pod_o} = '0;
    end
    // kind = {fetch, write, read, external_data_space}
    task send(input [3:0] k, input [15:0] a, input [7:0] d, input [2:0] l,
              input [7:0] p1, input [7:0] p3, input [3:0] pod);
        @(posedge clk_i);
        kind_o <= k;
        addr_o <= a;
        data_o <= d;
        lvl_o <= l;
        p1_o <= p1;
        p3_o <= p3;
        pod_o <= pod;
        repeat (4) @(posedge clk_i);
        bus_cycle_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus_cycle_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        // released bus shows garbage, not the last value
        addr_o <= ~a;
        data_o <= ~d;
        kind_o <= 4'h0;
    endtask
endmodule // trace_target_model
`default_nettype wire
